// [verilog/intctl_cfg.svh]
// register offsets, field positions, reset values and counts of the controller
`ifndef INTCTL_CFG_SVH
`define INTCTL_CFG_SVH

// ==========================================================
// register addresses
`define ADDR_EN_MAIN   8'ha8
`define ADDR_PRI_MAIN  8'hb8
`define ADDR_EXT_CFG   8'he4
`define ADDR_EN_EXT    8'he6
`define ADDR_PRI_EXT   8'hf6

// ==========================================================
// reset values
`define RST_EN_MAIN    8'h00
`define RST_PRI_MAIN   8'h00
`define RST_EXT_CFG    8'h00
`define RST_EN_EXT     8'h00
`define RST_PRI_EXT    8'h00

// ==========================================================
// fields
`define GLOBAL_EN_BIT  7
`define SRC_FIELD_W    6
`define EXT0_POL_BIT   3
`define EXT1_POL_BIT   7
`define EXT0_SRC       0
`define EXT1_SRC       2

// ==========================================================
// sources, vectors and timing
`define NUM_SRC        12
`define AUTO_CLR_MASK  12'h00f
`define VEC_BASE       16'h0003
`define VEC_STEP_LOG2  3
`define CALL_CYCLES    3'h4

`endif

// [verilog/intctl_pkg.sv]
// types shared by the interrupt controller files
package intctl_pkg;

  // ========================================================
  // register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_req_t;

  // ========================================================
  // instruction progress reported by the core
  typedef struct packed {
    logic instr_done;
    logic next_single;
    logic reti_done;
  } cpu_step_t;

  // ========================================================
  // call request towards the core
  typedef struct packed {
    logic        busy;
    logic [15:0] addr;
    logic [3:0]  src;
    logic        high;
  } call_t;

  typedef enum logic {ST_IDLE, ST_CALL} ctl_state_t;

endpackage : intctl_pkg

// [verilog/pending_flags.sv]
// twelve sticky pending flags with hardware and software set, software and automatic clear
`timescale 1ns/10ps
`include "intctl_cfg.svh"
module pending_flags (
  // clock and reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset,
  // set and clear strobes
  input  wire logic [`NUM_SRC-1:0]  i_trig,
  input  wire logic [`NUM_SRC-1:0]  i_sw_set,
  input  wire logic [`NUM_SRC-1:0]  i_sw_clr,
  input  wire logic [`NUM_SRC-1:0]  i_auto_clr,
  // flags
  output logic      [`NUM_SRC-1:0]  o_pending
);

  logic [`NUM_SRC-1:0] pend_ff;
  logic [`NUM_SRC-1:0] nxt_pend;

  // ========================================================
  // one flag per source; a set in the clear cycle wins
  genvar g;
  generate
    for (g = 0; g < `NUM_SRC; g++) begin : g_flag
      always_comb begin
        if (i_trig[g] || i_sw_set[g]) begin
          nxt_pend[g] = 1'b1;
        end else if (i_sw_clr[g] || i_auto_clr[g]) begin
          nxt_pend[g] = 1'b0;
        end else begin
          nxt_pend[g] = pend_ff[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  assign o_pending = pend_ff;

endmodule : pending_flags

// [verilog/prio_select.sv]
// picks the winning request: high level first, then lowest source order
`timescale 1ns/10ps
`include "intctl_cfg.svh"
module prio_select (
  // requests
  input  wire logic [`NUM_SRC-1:0] i_elig,
  input  wire logic [`NUM_SRC-1:0] i_high,
  // winner
  output logic                     o_valid,
  output logic [3:0]               o_idx,
  output logic                     o_high
);

  logic [`NUM_SRC-1:0] hi_req;

  always_comb begin
    hi_req  = i_elig & i_high;
    o_valid = |i_elig;
    o_high  = |hi_req;
    o_idx   = 4'h0;
    // downward scan so the lowest order number is kept
    for (int i = `NUM_SRC - 1; i >= 0; i--) begin
      if (o_high ? hi_req[i] : i_elig[i]) begin
        o_idx = 4'(i);
      end
    end
  end

endmodule : prio_select

// [verilog/intctl.sv]
// interrupt controller: enables, priorities, arbitration and call sequencing
`timescale 1ns/10ps
`include "intctl_cfg.svh"

// Notes on behaviour
// - twelve sources, each set to low or high priority.
// - a valid trigger condition sets that source's pending flag.
// - enabled pending source gets a long call after current instruction.
// - return resumes where execution would have gone without the call.
// - a disabled source's flag is ignored; no call is made.
// - flags are set whether or not the source is enabled.
// - source enables count only while global enable bit 7 is one.
// - global enable zero blocks every source.
// - after a clearing instruction, a single-cycle follower may still take it.
// - after a clearing instruction, a multi-cycle follower does not take it.
// - some sources have their flag cleared when the call vectors.
// - a flag still set after return re-enters after one instruction.
// - a software flag set acts exactly like a hardware trigger.
// - main enable at 0xa8, extended enable at 0xe6.
// - main priority at 0xb8, extended priority at 0xf6.
// - high preempts low service; high service is never preempted.
// - same-cycle requests: higher level first, then fixed source order.
// - sampled each clock; fastest entry five clocks after detection.
// - pending at return: one more instruction runs before the call.
module intctl (
  // clock and reset
  input  wire logic                     i_mclk,
  input  wire logic                     i_reset,
  // register access
  input  wire intctl_pkg::sfr_req_t     i_sfr,
  output logic [7:0]                    o_sfr_rdata,
  // flag sources
  input  wire logic [`NUM_SRC-1:0]      i_periph_trig,
  input  wire logic [1:0]               i_ext_line,
  input  wire logic [`NUM_SRC-1:0]      i_pend_set,
  input  wire logic [`NUM_SRC-1:0]      i_pend_clr,
  output logic [`NUM_SRC-1:0]           o_pending,
  // core handshake
  input  wire intctl_pkg::cpu_step_t    i_step,
  output intctl_pkg::call_t             o_call,
  output logic                          o_vector_taken,
  output logic [1:0]                    o_in_service
);

  import intctl_pkg::*;

  // ========================================================
  // registers
  logic [7:0]          en_main_ff;
  logic [7:0]          pri_main_ff;
  logic [7:0]          ext_cfg_ff;
  logic [7:0]          en_ext_ff;
  logic [7:0]          pri_ext_ff;
  logic [7:0]          rdata_ff;
  logic [7:0]          nxt_en_main;
  logic [7:0]          nxt_pri_main;
  logic [7:0]          nxt_ext_cfg;
  logic [7:0]          nxt_en_ext;
  logic [7:0]          nxt_pri_ext;
  logic [7:0]          nxt_rdata;

  always_comb begin
    nxt_en_main  = en_main_ff;
    nxt_pri_main = pri_main_ff;
    nxt_ext_cfg  = ext_cfg_ff;
    nxt_en_ext   = en_ext_ff;
    nxt_pri_ext  = pri_ext_ff;
    nxt_rdata    = rdata_ff;
    if (i_sfr.wr) begin
      unique case (i_sfr.addr)
        `ADDR_EN_MAIN:  nxt_en_main  = i_sfr.wdata;
        `ADDR_EN_EXT:   nxt_en_ext   = i_sfr.wdata;
        `ADDR_PRI_MAIN: nxt_pri_main = i_sfr.wdata;
        `ADDR_PRI_EXT:  nxt_pri_ext  = i_sfr.wdata;
        `ADDR_EXT_CFG:  nxt_ext_cfg  = i_sfr.wdata;
        default: ;
      endcase
    end
    if (i_sfr.rd) begin
      unique case (i_sfr.addr)
        `ADDR_EN_MAIN:  nxt_rdata = en_main_ff;
        `ADDR_EN_EXT:   nxt_rdata = en_ext_ff;
        `ADDR_PRI_MAIN: nxt_rdata = pri_main_ff;
        `ADDR_PRI_EXT:  nxt_rdata = pri_ext_ff;
        `ADDR_EXT_CFG:  nxt_rdata = ext_cfg_ff;
        // addresses owned by other blocks read as zero here
        default:        nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      en_main_ff  <= `RST_EN_MAIN;
      pri_main_ff <= `RST_PRI_MAIN;
      ext_cfg_ff  <= `RST_EXT_CFG;
      en_ext_ff   <= `RST_EN_EXT;
      pri_ext_ff  <= `RST_PRI_EXT;
      rdata_ff    <= 8'h00;
    end else begin
      en_main_ff  <= nxt_en_main;
      pri_main_ff <= nxt_pri_main;
      ext_cfg_ff  <= nxt_ext_cfg;
      en_ext_ff   <= nxt_en_ext;
      pri_ext_ff  <= nxt_pri_ext;
      rdata_ff    <= nxt_rdata;
    end
  end

  assign o_sfr_rdata = rdata_ff;

  // ========================================================
  // external lines: two flops, then edge detect on polarity
  logic [1:0]          ext_meta_ff;
  logic [1:0]          ext_sync_ff;
  logic [1:0]          ext_prev_ff;
  logic [1:0]          ext_act;
  logic [1:0]          nxt_ext_prev;
  logic [`NUM_SRC-1:0] trig;

  always_comb begin
    ext_act[0] = ext_sync_ff[0] ~^ ext_cfg_ff[`EXT0_POL_BIT];
    ext_act[1] = ext_sync_ff[1] ~^ ext_cfg_ff[`EXT1_POL_BIT];
    nxt_ext_prev = ext_act;
    trig = i_periph_trig;
    trig[`EXT0_SRC] = trig[`EXT0_SRC] | (ext_act[0] & ~ext_prev_ff[0]);
    trig[`EXT1_SRC] = trig[`EXT1_SRC] | (ext_act[1] & ~ext_prev_ff[1]);
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ext_meta_ff <= 2'h0;
      ext_sync_ff <= 2'h0;
      ext_prev_ff <= 2'h3;
    end else begin
      ext_meta_ff <= i_ext_line;
      ext_sync_ff <= ext_meta_ff;
      ext_prev_ff <= nxt_ext_prev;
    end
  end

  // ========================================================
  // pending flags
  logic [`NUM_SRC-1:0] pend;
  logic [`NUM_SRC-1:0] auto_clr;

  pending_flags u_flags (
    .i_mclk     (i_mclk),
    .i_reset    (i_reset),
    .i_trig     (trig),
    .i_sw_set   (i_pend_set),
    .i_sw_clr   (i_pend_clr),
    .i_auto_clr (auto_clr),
    .o_pending  (pend)
  );

  assign o_pending = pend;

  // ========================================================
  // eligibility and arbitration
  logic [`NUM_SRC-1:0] en_src;
  logic [`NUM_SRC-1:0] hi_src;
  logic [`NUM_SRC-1:0] elig;
  logic                in_low_ff;
  logic                in_high_ff;
  logic                win_valid;
  logic [3:0]          win_idx;
  logic                win_high;

  always_comb begin
    en_src = {en_ext_ff[`SRC_FIELD_W-1:0], en_main_ff[`SRC_FIELD_W-1:0]};
    hi_src = {pri_ext_ff[`SRC_FIELD_W-1:0],
              pri_main_ff[`SRC_FIELD_W-1:0]};
    elig = pend & en_src;
    if (!en_main_ff[`GLOBAL_EN_BIT]) begin
      elig = '0;
    end
    // a running high routine blocks all; a running low one blocks low
    if (in_high_ff) begin
      elig = '0;
    end else if (in_low_ff) begin
      elig = elig & hi_src;
    end
  end

  prio_select u_prio (
    .i_elig  (elig),
    .i_high  (hi_src),
    .o_valid (win_valid),
    .o_idx   (win_idx),
    .o_high  (win_high)
  );

  // ========================================================
  // detection stage: one clock from flag to sampled request
  logic                req_valid_ff;
  logic [3:0]          req_idx_ff;
  logic                req_high_ff;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      req_valid_ff <= 1'b0;
      req_idx_ff   <= 4'h0;
      req_high_ff  <= 1'b0;
    end else begin
      req_valid_ff <= win_valid;
      req_idx_ff   <= win_idx;
      req_high_ff  <= win_high;
    end
  end

  // ========================================================
  // call sequencing
  ctl_state_t          state_ff;
  ctl_state_t          nxt_state;
  logic [2:0]          cnt_ff;
  logic [2:0]          nxt_cnt;
  logic [3:0]          src_ff;
  logic [3:0]          nxt_src;
  logic                lvl_ff;
  logic                nxt_lvl;
  localparam logic [`NUM_SRC-1:0] auto_mask = `AUTO_CLR_MASK;
  logic                nxt_in_low;
  logic                nxt_in_high;
  logic                taken_ff;
  logic                nxt_taken;
  logic                take;
  logic [15:0]         vec_addr;

  always_comb begin
    // a single-cycle follower sees the request sampled before the
    // enable cleared; a multi-cycle one is qualified afresh.
    // the return boundary never calls, so one more instruction runs
    take = i_step.instr_done && req_valid_ff && !i_step.reti_done
           && (i_step.next_single || elig[req_idx_ff]);
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_src     = src_ff;
    nxt_lvl     = lvl_ff;
    nxt_in_low  = in_low_ff;
    nxt_in_high = in_high_ff;
    nxt_taken   = 1'b0;
    auto_clr    = '0;
    if (i_step.reti_done) begin
      // a flag left set re-requests as soon as the level is popped
      if (in_high_ff) begin
        nxt_in_high = 1'b0;
      end else begin
        nxt_in_low = 1'b0;
      end
    end
    unique case (state_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_state = ST_CALL;
          nxt_cnt   = `CALL_CYCLES - 3'h1;
          nxt_src   = req_idx_ff;
          nxt_lvl   = req_high_ff;
        end
      end
      ST_CALL: begin
        if (cnt_ff == 3'h0) begin
          nxt_state = ST_IDLE;
          nxt_taken = 1'b1;
          auto_clr[src_ff] = auto_mask[src_ff];
          if (lvl_ff) begin
            nxt_in_high = 1'b1;
          end else begin
            nxt_in_low = 1'b1;
          end
        end else begin
          nxt_cnt = cnt_ff - 3'h1;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_ff   <= ST_IDLE;
      cnt_ff     <= 3'h0;
      src_ff     <= 4'h0;
      lvl_ff     <= 1'b0;
      in_low_ff  <= 1'b0;
      in_high_ff <= 1'b0;
      taken_ff   <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      src_ff     <= nxt_src;
      lvl_ff     <= nxt_lvl;
      in_low_ff  <= nxt_in_low;
      in_high_ff <= nxt_in_high;
      taken_ff   <= nxt_taken;
    end
  end

  // ========================================================
  // outputs
  always_comb begin
    // vector slots are eight bytes apart above the reset entry
    vec_addr = `VEC_BASE + (16'(src_ff) << `VEC_STEP_LOG2);
  end

  assign o_call.busy     = (state_ff == ST_CALL);
  assign o_call.addr     = vec_addr;
  assign o_call.src      = src_ff;
  assign o_call.high     = lvl_ff;
  assign o_vector_taken  = taken_ff;
  assign o_in_service    = {in_high_ff, in_low_ff};

endmodule : intctl

// [testbench/intctl_assertions.sv]
// port-level checks of the interrupt controller
`timescale 1ns/10ps
`include "intctl_cfg.svh"
module intctl_assertions (
  // clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_reset,
  // watched ports
  input  wire intctl_pkg::sfr_req_t  i_sfr,
  input  wire logic [7:0]            o_sfr_rdata,
  input  wire logic [`NUM_SRC-1:0]   i_periph_trig,
  input  wire logic [`NUM_SRC-1:0]   i_pend_set,
  input  wire logic [`NUM_SRC-1:0]   o_pending,
  input  wire intctl_pkg::cpu_step_t i_step,
  input  wire intctl_pkg::call_t     o_call,
  input  wire logic                  o_vector_taken,
  input  wire logic [1:0]            o_in_service
);
  import intctl_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  logic unmapped;
  assign unmapped = !(i_sfr.addr inside {`ADDR_EN_MAIN, `ADDR_PRI_MAIN,
                      `ADDR_EXT_CFG, `ADDR_EN_EXT, `ADDR_PRI_EXT});
  // ==========================================================
  // call sequence
  sequence s_call;
    o_call.busy [*4] ##1 (!o_call.busy && o_vector_taken);
  endsequence
  property p_call_len;
    $rose(o_call.busy) |-> s_call;
  endproperty
  a_call_len: assert property (p_call_len)
    else $error("call length wrong");
  property p_call_cause;
    $rose(o_call.busy) |-> $past(i_step.instr_done);
  endproperty
  a_call_cause: assert property (p_call_cause)
    else $error("call without boundary");
  property p_vec_addr;
    o_call.busy |-> o_call.addr == `VEC_BASE + {9'h000, o_call.src, 3'b000};
  endproperty
  a_vec_addr: assert property (p_vec_addr)
    else $error("vector address wrong");
  property p_autoclr;
    $fell(o_call.busy) && $past(o_call.src) < 4
      |-> !o_pending[$past(o_call.src)];
  endproperty
  a_autoclr: assert property (p_autoclr)
    else $error("flag not cleared on vector");
  property p_in_svc;
    $fell(o_call.busy) |-> o_in_service[$past(o_call.high)];
  endproperty
  a_in_svc: assert property (p_in_svc)
    else $error("service level not entered");
  property p_no_preempt;
    $rose(o_call.busy) |-> !o_in_service[1];
  endproperty
  a_no_preempt: assert property (p_no_preempt)
    else $error("high service preempted");
  property p_high_only;
    $rose(o_call.busy) && o_in_service[0] |-> o_call.high;
  endproperty
  a_high_only: assert property (p_high_only)
    else $error("low preempted low");
  // ==========================================================
  // flags and registers
  property p_flag_set;
    |(i_periph_trig | i_pend_set) |=>
      (o_pending & $past(i_periph_trig)) == $past(i_periph_trig) &&
      (o_pending & $past(i_pend_set)) == $past(i_pend_set);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set");
  property p_unmapped;
    i_sfr.rd && unmapped |=> o_sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule : intctl_assertions

// [testbench/cpu_step_model.sv]
// behavioural core reporting instruction boundaries and returns
`timescale 1ns/10ps
module cpu_step_model (
  // clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_reset,
  // program behaviour
  input  wire logic [7:0]            i_gap,
  input  wire logic                  i_single,
  input  wire logic                  i_reti,
  input  wire intctl_pkg::call_t     i_call,
  // boundary reports
  output intctl_pkg::cpu_step_t      o_step
);
  import intctl_pkg::*;
  logic [7:0] cnt;
  logic       reti_pend;
  // ==========================================================
  // the pipeline stalls while a call runs, so no boundary then
  always @(posedge i_mclk) begin
    if (i_reset) begin
      cnt       <= 8'h00;
      reti_pend <= 1'b0;
      o_step    <= '0;
    end else if (i_call.busy) begin
      cnt    <= 8'h00;
      o_step <= '0;
    end else if (cnt >= i_gap) begin
      cnt       <= 8'h00;
      reti_pend <= 1'b0;
      o_step    <= '{1'b1, i_single, reti_pend | i_reti};
    end else begin
      cnt       <= cnt + 8'h01;
      reti_pend <= reti_pend | i_reti;
      o_step    <= '0;
    end
  end
endmodule : cpu_step_model

// [testbench/intctl_tb.sv]
// self-checking bench of the interrupt controller
`timescale 1ns/10ps
`include "intctl_cfg.svh"
module intctl_tb;
  import intctl_pkg::*;
  // ==========================================================
  // stimulus, model state and wiring
  logic        i_mclk  = 1'b0;
  logic        i_reset = 1'b1;
  sfr_req_t    sfr     = '0;
  logic [7:0]  rdata;
  logic [11:0] trig    = '0;
  logic [1:0]  ext     = '0;
  logic [11:0] pset    = '0;
  logic [11:0] pclr    = '0;
  logic [11:0] pend;
  cpu_step_t   step;
  call_t       call;
  logic [7:0]  gap     = 8'h02;
  logic        single  = 1'b1;
  logic        reti    = 1'b0;
  int          fails   = 0;
  int          checks  = 0;
  int          pmod    = 0;
  logic [31:0] seed    = 32'hced22e99;
  logic [7:0]  rmod [5];
  logic [7:0]  adr [5] = '{`ADDR_EN_MAIN, `ADDR_PRI_MAIN, `ADDR_EXT_CFG,
                           `ADDR_EN_EXT, `ADDR_PRI_EXT};
  always #12.5 i_mclk = ~i_mclk;
  intctl u_intctl (.i_mclk(i_mclk), .i_reset(i_reset), .i_sfr(sfr),
    .o_sfr_rdata(rdata), .i_periph_trig(trig), .i_ext_line(ext),
    .i_pend_set(pset), .i_pend_clr(pclr), .o_pending(pend),
    .i_step(step), .o_call(call), .o_vector_taken(), .o_in_service());
  cpu_step_model u_cpu_step_model (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_gap(gap), .i_single(single), .i_reti(reti), .i_call(call),
    .o_step(step));
  // ==========================================================
  // helpers and compares
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic note(input bit ok, input string what);
    checks++;
    if (!ok) begin
      fails++;
      $display("ERROR %0t %s mismatch", $time, what);
    end
  endtask : note
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    note(got === exp, "register");
  endtask : chk_reg
  task automatic chk_pend();
    note(pend === 12'(pmod), "pending");
  endtask : chk_pend
  task automatic chk_vec(input logic [15:0] got, input int s);
    note(got === 16'(3 + 8 * s), "vector");
  endtask : chk_vec
  task automatic chk_lat(input int got, input int exp);
    note(got == exp, "call latency");
  endtask : chk_lat
  task automatic chk_idle(input int n);
    bit seen;
    seen = 0;
    repeat (n) begin
      @(negedge i_mclk);
      if (call.busy !== 1'b0) seen = 1;
    end
    note(!seen, "unexpected call");
  endtask : chk_idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    sfr <= '{a, d, 1'b1, 1'b0};
    @(posedge i_mclk);
    sfr.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    sfr <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_mclk);
    sfr.rd <= 1'b0;
    @(negedge i_mclk);
    chk_reg(rdata, exp);
  endtask : rd
  task automatic cfg(input logic [11:0] en, input logic g,
                     input logic [11:0] hi);
    wr(`ADDR_EN_MAIN, {g, 1'b0, en[5:0]});
    wr(`ADDR_EN_EXT, {2'b00, en[11:6]});
    wr(`ADDR_PRI_MAIN, {2'b00, hi[5:0]});
    wr(`ADDR_PRI_EXT, {2'b00, hi[11:6]});
  endtask : cfg
  task automatic pulse(input logic [11:0] m, input bit hw);
    @(posedge i_mclk);
    if (hw) trig <= m;
    else pset <= m;
    @(posedge i_mclk);
    trig <= '0;
    pset <= '0;
    pmod = pmod | m;
    @(negedge i_mclk);
  endtask : pulse
  task automatic clr(input logic [11:0] m);
    @(posedge i_mclk);
    pclr <= m;
    @(posedge i_mclk);
    pclr <= '0;
    pmod = pmod & ~m;
  endtask : clr
  task automatic take(input int s, input int due = 0);
    int n;
    n = 0;
    while (call.busy !== 1'b1 && n < 300) begin
      @(negedge i_mclk);
      n++;
    end
    if (due > 0) chk_lat(n, due);
    chk_vec(call.busy ? call.addr : 16'hffff, s);
    while (call.busy === 1'b1 && n < 600) begin
      @(negedge i_mclk);
      n++;
    end
    if (s < 4) pmod = pmod & ~(1 << s);
    chk_pend();
  endtask : take
  task automatic ret();
    @(posedge i_mclk);
    reti <= 1'b1;
    @(posedge i_mclk);
    reti <= 1'b0;
    for (int n = 0; n < 80 && step.reti_done !== 1'b1; n++) @(negedge i_mclk);
  endtask : ret
  // the enable clear lands on the same clock as the next boundary, so the
  // request sampled earlier is still standing when that boundary comes
  task automatic late_clr(input logic sgl);
    cfg(12'h001, 1'b1, 12'h000);
    @(posedge i_mclk);
    gap    <= 8'd30;
    single <= sgl;
    @(negedge i_mclk);
    for (int n = 0; n < 40 && step.instr_done !== 1'b1; n++) @(negedge i_mclk);
    pulse(12'h001, 1'b0);
    repeat (27) @(posedge i_mclk);
    wr(`ADDR_EN_MAIN, 8'h00);
  endtask : late_clr
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  // ==========================================================
  // scenarios
  initial begin
    logic [7:0] v;
    int         s;
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    for (int i = 0; i < 5; i++) rd(adr[i], 8'h00);
    rd(8'h80, 8'h00);
    for (int i = 0; i < 5; i++) begin
      v = 8'(rnd());
      v[7] = (i == 0) ? 1'b0 : v[7];
      wr(adr[i], v);
      rmod[i] = v;
    end
    for (int i = 0; i < 5; i++) rd(adr[i], rmod[i]);
    wr(`ADDR_EXT_CFG, 8'h88);
    clr(12'hfff);
    @(posedge i_mclk);
    ext <= 2'b11;
    repeat (6) @(negedge i_mclk);
    pmod = 12'h005;
    chk_pend();
    @(posedge i_mclk);
    ext <= 2'b00;
    clr(12'h005);
    s = int'(rnd() % 12);
    cfg(12'h000, 1'b1, 12'h000);
    pulse(12'(1 << s), 1'b1);
    chk_pend();
    chk_idle(40);
    cfg(12'(1 << s), 1'b0, 12'h000);
    chk_idle(40);
    cfg(12'(1 << s), 1'b1, 12'h000);
    take(s);
    clr(12'(1 << s));
    ret();
    cfg(12'hfff, 1'b1, 12'h000);
    for (int k = 0; k < 12; k++) begin
      pulse(12'(1 << k), 1'b0);
      take(k);
      if (k >= 4) begin
        ret();
        // return boundary, one instruction of gap+1 clocks, then the call
        take(k, int'(gap) + 2);
      end
      clr(12'(1 << k));
      ret();
    end
    cfg(12'hfff, 1'b1, 12'h020);
    pulse(12'h022, 1'b0);
    take(5);
    clr(12'h020);
    ret();
    take(1, int'(gap) + 2);
    ret();
    pulse(12'h00c, 1'b0);
    take(2);
    ret();
    take(3, int'(gap) + 2);
    ret();
    pulse(12'h010, 1'b0);
    take(4);
    pulse(12'h020, 1'b0);
    take(5);
    clr(12'h030);
    ret();
    ret();
    late_clr(1'b0);
    chk_idle(80);
    clr(12'h001);
    late_clr(1'b1);
    take(0);
    rd(`ADDR_EN_MAIN, 8'h00);
    ret();
    conclude();
  end
  initial begin
    #500000;
    fails++;
    conclude();
  end
endmodule : intctl_tb

bind intctl intctl_assertions u_intctl_assertions (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_sfr(i_sfr),
  .o_sfr_rdata(o_sfr_rdata), .i_periph_trig(i_periph_trig),
  .i_pend_set(i_pend_set), .o_pending(o_pending), .i_step(i_step),
  .o_call(o_call), .o_vector_taken(o_vector_taken),
  .o_in_service(o_in_service));
